/* File: rtl/lpm_sequencer.sv */
// lpm_sequencer: low-power mode sequencer with apb register file
// assumes core gives one-cycle wfi and exception-return pulses on clk_sys
module lpm_sequencer
  import lpm_pkg::*;
// Overview of operation
// - unmasked priority interrupt wakes from sleep
// - leaving sleep returns to run
// - gated-clock source interrupts never wake sleep
// - core power stays on in wait/retention
// - only 32k clocks run in wait/retention
// - only enabled async sources and always-on sources 0 and 1 wake deep modes
// - wake raises wake interrupt and records cause
// - leaving wait/retention returns to run
// - sleep-on-return also applies to deep modes
#(
  parameter int NW = NUM_WAKE
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          wfi_pulse,
  input  wire logic          exc_return_pulse,
  input  wire logic          irq_pending,
  input  wire logic [NW-1:0] periph_irq,
  input  wire logic [NW-1:0] periph_clk_on,
  input  wire logic [NW-1:0] async_wake_in,
  input  wire logic          crystal_32k_clock_en,
  input  wire logic          rc_32k_clock_en,
  output logic               core_clk_en,
  output logic               periph_clk_en,
  output logic               clk32k_xtal_en,
  output logic               clk32k_rc_en,
  output logic               core_pwr_on,
  output logic               asleep_op_allow,
  output logic               wake_interrupt_line,
  output logic [1:0]         mode
);
  typedef enum logic [3:0] {
    ST_RUN  = 4'b0001,
    ST_SLP  = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_RET  = 4'b1000
  } lpm_state_t;

  lpm_state_t st_r, st_nxt;
  logic [CTRL_W-1:0] ctrl_r;
  logic [NW-1:0]     awen_r;
  logic [NW-1:0]     cause_r;
  logic              irqen_r;
  logic [NW-1:0]     wake_s;
  logic [NW-1:0]     wake_q;
  logic [NW-1:0]     wake_rise;
  logic              wr_acc;
  logic              rd_acc;
  logic              entry_req;
  logic              deep;
  logic              sleep_wake;

  lpm_sync #(.W(NW)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (async_wake_in),
    .q       (wake_s)
  );

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !pwrite;
  assign deep   = ctrl_r[CTRL_DEEP_BIT] && !ctrl_r[CTRL_BKUP_BIT];
  assign entry_req = wfi_pulse || (exc_return_pulse && ctrl_r[CTRL_SOR_BIT]);
  assign sleep_wake = irq_pending || |(periph_irq & periph_clk_on);
  assign wake_rise = wake_s & ~wake_q & (awen_r | ALWAYS_ON);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_RUN: begin
        if (entry_req && !ctrl_r[CTRL_BKUP_BIT]) begin
          if (!deep) st_nxt = ST_SLP;
          else if (ctrl_r[CTRL_RET_BIT]) st_nxt = ST_RET;
          else st_nxt = ST_WAIT;
        end
      end
      ST_SLP:  if (sleep_wake) st_nxt = ST_RUN;
      ST_WAIT: if (|wake_rise) st_nxt = ST_RUN;
      ST_RET:  if (|wake_rise) st_nxt = ST_RUN;
      default: st_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) st_r <= ST_RUN;
    else st_r <= st_nxt;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) wake_q <= '0;
    else wake_q <= wake_s;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= CTRL_RST;
      awen_r  <= AWEN_RST;
      irqen_r <= 1'b0;
    end else if (wr_acc) begin
      if (hit(paddr, OFF_CTRL))  ctrl_r  <= pwdata[CTRL_W-1:0];
      if (hit(paddr, OFF_AWEN))  awen_r  <= pwdata[NW-1:0];
      if (hit(paddr, OFF_IRQEN)) irqen_r <= pwdata[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cause_r <= '0;
    else if ((st_r == ST_WAIT) || (st_r == ST_RET))
      cause_r <= cause_r | wake_rise;
    else if (wr_acc && hit(paddr, OFF_CAUSE))
      cause_r <= cause_r & ~pwdata[NW-1:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) wake_interrupt_line <= 1'b0;
    else wake_interrupt_line <= irqen_r && (|cause_r);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_clk_en     <= 1'b1;
      periph_clk_en   <= 1'b1;
      clk32k_xtal_en  <= 1'b0;
      clk32k_rc_en    <= 1'b0;
      core_pwr_on     <= 1'b1;
      asleep_op_allow <= 1'b0;
      mode            <= MODE_RUN;
    end else begin
      core_clk_en     <= (st_nxt == ST_RUN);
      periph_clk_en   <= (st_nxt == ST_RUN) || (st_nxt == ST_SLP);
      clk32k_xtal_en  <= crystal_32k_clock_en;
      clk32k_rc_en    <= rc_32k_clock_en;
      core_pwr_on     <= 1'b1;
      asleep_op_allow <= (st_nxt == ST_SLP) || (st_nxt == ST_WAIT);
      case (st_nxt)
        ST_SLP:  mode <= MODE_SLP;
        ST_WAIT: mode <= MODE_WAIT;
        ST_RET:  mode <= MODE_RET;
        default: mode <= MODE_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(hit(paddr, OFF_CTRL) || hit(paddr, OFF_AWEN)
                 || hit(paddr, OFF_CAUSE) || hit(paddr, OFF_STATUS) || hit(paddr, OFF_IRQEN));
      if (rd_acc && !penable) begin
        prdata <= '0;
        if (hit(paddr, OFF_CTRL))   prdata <= {26'h0, ctrl_r};
        if (hit(paddr, OFF_AWEN))   prdata <= {24'h0, awen_r};
        if (hit(paddr, OFF_CAUSE))  prdata <= {24'h0, cause_r};
        if (hit(paddr, OFF_STATUS)) prdata <= {28'h0, st_r};
        if (hit(paddr, OFF_IRQEN))  prdata <= {31'h0, irqen_r};
      end
    end
  end

  a_core_power: assert property (@(posedge clk_sys) disable iff (!rst_n)
    core_pwr_on)
    else $error("core power dropped");
  a_sleep_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == ST_SLP && sleep_wake) |=> (st_r == ST_RUN) ##1 core_clk_en)
    else $error("sleep did not wake");
  a_gated_src: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == ST_SLP && !irq_pending && !(|(periph_irq & periph_clk_on))) |=> st_r == ST_SLP)
    else $error("gated source woke sleep");
  a_deep_clocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == ST_WAIT || st_r == ST_RET) |-> (!core_clk_en && !periph_clk_en))
    else $error("clocks running in deep mode");
  a_deep_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == ST_RUN && entry_req && deep && ctrl_r[CTRL_RET_BIT]) |=> st_r == ST_RET)
    else $error("retention not entered");
  a_deep_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == ST_WAIT && |wake_rise) |=> st_r == ST_RUN ##1 mode == MODE_RUN)
    else $error("wait not left");
  a_ret_noop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == ST_RET) |-> !asleep_op_allow)
    else $error("asleep op in retention");
  a_cause_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == ST_RET && |wake_rise) |=> (cause_r & $past(wake_rise)) == $past(wake_rise))
    else $error("cause not recorded");
  a_awen_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == ST_WAIT && !(|(wake_s & ~wake_q & (awen_r | ALWAYS_ON)))) |=> st_r == ST_WAIT)
    else $error("disabled source woke");
  a_sor_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r == ST_RUN && exc_return_pulse && ctrl_r[CTRL_SOR_BIT] && !ctrl_r[CTRL_BKUP_BIT])
    |=> st_r != ST_RUN)
    else $error("sleep on return ignored");
endmodule

/* File: rtl/lpm_pkg.sv */
// lpm_pkg: register map, field layout and mode encodings of the low-power sequencer
// assumes an apb slave with 32-bit data on clk_sys
package lpm_pkg;
  localparam int NUM_WAKE = 8;
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_AWEN   = 12'h004;
  localparam logic [11:0] OFF_CAUSE  = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFF_IRQEN  = 12'h010;
  localparam int CTRL_SLEEP_LSB = 0;
  localparam int CTRL_SLEEP_W   = 2;
  localparam int CTRL_RET_BIT   = 2;
  localparam int CTRL_BKUP_BIT  = 3;
  localparam int CTRL_DEEP_BIT  = 4;
  localparam int CTRL_SOR_BIT   = 5;
  localparam int CTRL_W         = 6;
  localparam logic [CTRL_W-1:0]   CTRL_RST  = 6'h00;
  localparam logic [NUM_WAKE-1:0] AWEN_RST  = 8'h00;
  localparam logic [NUM_WAKE-1:0] ALWAYS_ON = 8'h03;
  localparam logic [1:0] MODE_RUN  = 2'h0;
  localparam logic [1:0] MODE_SLP  = 2'h1;
  localparam logic [1:0] MODE_WAIT = 2'h2;
  localparam logic [1:0] MODE_RET  = 2'h3;
endpackage

/* File: rtl/lpm_sync.sv */
// lpm_sync: two-flop synchroniser for a vector of asynchronous levels
// assumes inputs are quasi-static against clk_sys
module lpm_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= d;
      q    <= s1_r;
    end
  end
endmodule

/* File: test/lpm_core_model.sv */
// lpm_core_model: core and wake-source stand-in for the sequencer
// assumes clk_sys from the bench; every change lands just after a rising edge
module lpm_core_model (
  input  wire logic       clk_sys,
  output logic            wfi_pulse,
  output logic            exc_return_pulse,
  output logic [7:0]      async_wake_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wfi_pulse = 1'b0;
    exc_return_pulse = 1'b0;
    async_wake_in = 8'h00;
  end
  task automatic sleep_req(input bit sor);
    @(posedge clk_sys);
    if (sor) exc_return_pulse <= 1'b1;
    else wfi_pulse <= 1'b1;
    @(posedge clk_sys);
    wfi_pulse <= 1'b0;
    exc_return_pulse <= 1'b0;
  endtask
  // async source rises, holds, then idles low
  task automatic wake(input int i, input int hold);
    @(posedge clk_sys);
    async_wake_in[i] <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    async_wake_in[i] <= 1'b0;
  endtask
endmodule

/* File: test/testbench.sv */
// testbench: apb-driven checks of the low-power sequencer
// assumes lpm_core_model stands in for the core and the wake sources
module testbench
  import lpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, se;
  logic        irq_pending, crystal_32k_clock_en, rc_32k_clock_en, wfi_pulse, exc_return_pulse;
  logic        core_clk_en, periph_clk_en, clk32k_xtal_en, clk32k_rc_en;
  logic        core_pwr_on, asleep_op_allow, wake_interrupt_line;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  periph_irq, periph_clk_on, async_wake_in;
  logic [1:0]  mode;
  int          num_errors = 0;
  int          checks = 0;
  lpm_sequencer u_lpm_sequencer (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .wfi_pulse, .exc_return_pulse, .irq_pending,
    .periph_irq, .periph_clk_on, .async_wake_in, .crystal_32k_clock_en, .rc_32k_clock_en, .core_clk_en,
    .periph_clk_en, .clk32k_xtal_en, .clk32k_rc_en, .core_pwr_on, .asleep_op_allow,
    .wake_interrupt_line, .mode);
  lpm_core_model u_lpm_core_model (.clk_sys, .wfi_pulse, .exc_return_pulse, .async_wake_in);
  always #4 clk_sys = ~clk_sys;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      num_errors++;
      finish_test;
    end
  endtask
  task automatic wm(input logic [1:0] m);
    int n;
    n = 0;
    while (mode !== m && n < 16) begin
      @(posedge clk_sys);
      n++;
    end
    chk(mode, m);
    if (mode !== m) finish_test;
  endtask
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, irq_pending, rc_32k_clock_en} = '0;
    {periph_irq, periph_clk_on} = '0;
    crystal_32k_clock_en = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(0, OFF_CTRL, 0);
    chk({rd[5:0], core_pwr_on, mode}, 9'h004);
    apb(1, 12'h020, 32'hFF);
    chk(se, 1'b1);
    $display("reset test done");
    apb(1, OFF_CTRL, 32'h1);
    u_lpm_core_model.sleep_req(0);
    wm(MODE_SLP);
    periph_irq <= 8'h08;
    repeat (6) @(posedge clk_sys);
    chk({mode, core_clk_en, periph_clk_en}, {MODE_SLP, 2'b01});
    periph_clk_on <= 8'h08;
    wm(MODE_RUN);
    periph_irq <= 8'h00;
    u_lpm_core_model.sleep_req(0);
    wm(MODE_SLP);
    irq_pending <= 1'b1;
    wm(MODE_RUN);
    irq_pending <= 1'b0;
    apb(0, OFF_STATUS, 0);
    chk(rd, 32'h1);
    $display("sleep test done");
    apb(1, OFF_IRQEN, 32'h1);
    apb(1, OFF_CTRL, 32'h10);
    u_lpm_core_model.sleep_req(0);
    wm(MODE_WAIT);
    chk(core_pwr_on, 1'b1);
    chk({core_clk_en, periph_clk_en, clk32k_xtal_en, clk32k_rc_en}, 4'h2);
    u_lpm_core_model.wake(2, 6);
    chk(mode, MODE_WAIT);
    u_lpm_core_model.wake(0, 6);
    wm(MODE_RUN);
    chk(wake_interrupt_line, 1'b1);
    apb(0, OFF_CAUSE, 0);
    chk(rd, 32'h1);
    apb(0, OFF_CAUSE, 0);
    chk(rd, 32'h1);
    apb(1, OFF_CAUSE, 32'h1);
    apb(0, OFF_CAUSE, 0);
    chk(rd, 32'h0);
    chk(wake_interrupt_line, 1'b0);
    $display("wait test done");
    rc_32k_clock_en <= 1'b1;
    apb(1, OFF_AWEN, 32'h04);
    apb(1, OFF_CTRL, 32'h34);
    u_lpm_core_model.sleep_req(1);
    wm(MODE_RET);
    chk(asleep_op_allow, 1'b0);
    chk({core_clk_en, periph_clk_en, clk32k_xtal_en, clk32k_rc_en}, 4'h3);
    chk(core_pwr_on, 1'b1);
    u_lpm_core_model.wake(2, 2);
    wm(MODE_RUN);
    apb(0, OFF_CAUSE, 0);
    chk(rd, 32'h4);
    apb(1, OFF_CTRL, 32'h18);
    u_lpm_core_model.sleep_req(0);
    repeat (3) @(posedge clk_sys);
    chk(mode, MODE_RUN);
    $display("retention test done");
    finish_test;
  end
endmodule
